// >>> src/ivpu_unit.sv
// interrupt vector and priority unit: flags, priorities, vector choice
// assumes all sources and the core run on clk_i; core reads the vector
//
// The placing of the registers and the strobed register port are this design's own decisions.
module ivpu_unit
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // request sources
   input wire logic [ivpu_pkg::IVPU_NUM_REQ-1:0] src_req_i,
   input wire logic [7:0] dma_done_i,
   input wire logic [1:0] can_tx_i,
   input wire logic [3:0] cmp_i,
   input wire logic [3:0] tmr_i,
   input wire logic [1:0] i2c2_i,
   input wire logic [1:0] ext_i,
   input wire logic [1:0] ser_err_i,
   input wire logic [ivpu_pkg::IVPU_NUM_TRAPS-1:0] trap_i,
   // core side
   input wire logic [2:0] ipl_i,
   output logic irq_o,
   output logic trap_o,
   output logic [6:0] vec_num_o,
   output logic [23:0] vec_addr_o,
   output logic [2:0] irq_level_o
);
   import ivpu_pkg::*;

   // ************************************************
   // functions
   // ************************************************
   function automatic logic [7:0] reg_index
      (input logic [7:0] a, input logic [7:0] base);
      return a - base;
   endfunction : reg_index

   function automatic logic [23:0] vec_addr
      (input logic alt, input logic [6:0] num);
      return (alt ? IVPU_ALT_BASE : IVPU_PRI_BASE)
         + {16'h0, num, 1'b0}; // [RULE_01] [RULE_02] [RULE_16]
   endfunction : vec_addr

   // ************************************************
   // state
   // ************************************************
   logic [IVPU_REQ_SPACE-1:0] flags_reg;
   logic [IVPU_REQ_SPACE-1:0] flags_next;
   logic [15:0] prio_reg [IVPU_PRIO_REGS];
   logic alt_reg;
   logic irq_reg;
   logic trap_reg;
   logic [6:0] vnum_reg;
   logic [23:0] vaddr_reg;
   logic [2:0] lvl_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [IVPU_REQ_SPACE-1:0] req_vec;
   logic [3*IVPU_REQ_SPACE-1:0] prio_flat;

   // ************************************************
   // source routing
   // ************************************************
   always_comb
   begin
      req_vec = '0;
      req_vec[IVPU_NUM_REQ-1:0] = src_req_i;
      for (int i = 0; i < 8; i++)
      begin
         req_vec[IVPU_DMA_REQ[i]] = dma_done_i[i]; // [RULE_04]
      end
      for (int i = 0; i < 2; i++)
      begin
         req_vec[IVPU_CAN_TX_REQ[i]] = can_tx_i[i]; // [RULE_05]
         req_vec[IVPU_I2C2_REQ[i]] = i2c2_i[i]; // [RULE_07]
         req_vec[IVPU_EXT_REQ[i]] = ext_i[i]; // [RULE_07]
         req_vec[IVPU_SER_ERR_REQ[i]] = ser_err_i[i]; // [RULE_10]
      end
      for (int i = 0; i < 4; i++)
      begin
         req_vec[IVPU_CMP_REQ[i]] = cmp_i[i]; // [RULE_06]
         req_vec[IVPU_TMR_REQ[i]] = tmr_i[i]; // [RULE_06]
      end
      // reserved numbers carry nothing, whatever the port shows
      req_vec = req_vec & IVPU_REQ_IMPL; // [RULE_03]
   end

   // ************************************************
   // address decode
   // ************************************************
   wire logic [7:0] flag_idx8 = reg_index(addr_i, IVPU_FLAG_BASE);
   wire logic [7:0] prio_idx8 = reg_index(addr_i, IVPU_PRIO_BASE);
   // offset wraps below the base, so one compare covers both ends
   wire logic flag_sel = flag_idx8 < IVPU_FLAG_END - IVPU_FLAG_BASE;
   wire logic prio_sel = prio_idx8 < IVPU_PRIO_END - IVPU_PRIO_BASE;
   wire logic ctrl_sel = addr_i == IVPU_CTRL_ADDR;
   wire logic stat_sel = addr_i == IVPU_STAT_ADDR;
   wire logic [2:0] flag_idx = flag_idx8[2:0];
   wire logic [4:0] prio_idx = prio_idx8[4:0];
   wire logic [6:0] flag_lsb = {flag_idx, 4'h0};

   // ************************************************
   // request flags
   // ************************************************
   // a source pulse in the same cycle as a software clear still lands
   always_comb
   begin
      flags_next = flags_reg;
      if (wr_i && flag_sel)
      begin
         flags_next[flag_lsb +: 16] = wdata_i; // [RULE_08]
      end
      flags_next = (flags_next | req_vec) & IVPU_REQ_IMPL; // [RULE_08] [RULE_12]
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         flags_reg <= '0; // [RULE_09]
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   // ************************************************
   // priority and control registers
   // ************************************************
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (int k = 0; k < IVPU_PRIO_REGS; k++)
         begin
            prio_reg[k] <= IVPU_PRIO_RST; // [RULE_14]
         end
         alt_reg <= 1'b0;
      end
      else
      begin
         if (wr_i && prio_sel)
         begin
            prio_reg[prio_idx] <= wdata_i & IVPU_PRIO_MASK; // [RULE_14]
         end
         if (wr_i && ctrl_sel)
         begin
            alt_reg <= wdata_i[IVPU_CTRL_ALT_BIT]; // [RULE_16]
         end
      end
   end

   // field j of register k belongs to request 4k+j
   for (genvar k = 0; k < IVPU_PRIO_REGS; k++)
   begin : g_reg
      for (genvar j = 0; j < IVPU_FIELDS_PER_REG; j++)
      begin : g_fld
         assign prio_flat[(k*IVPU_FIELDS_PER_REG+j)*IVPU_PRIO_W +: 3] =
            prio_reg[k][j*IVPU_FIELD_STRIDE +: 3]; // [RULE_13]
      end
   end
   assign prio_flat[3*IVPU_REQ_SPACE-1:
                    3*IVPU_FIELDS_PER_REG*IVPU_PRIO_REGS] = '0;

   // ************************************************
   // vector selection
   // ************************************************
   wire logic arb_win;
   wire logic [6:0] arb_idx;
   wire logic [2:0] arb_lvl;

   ivpu_arbiter #(.N(IVPU_REQ_SPACE)) u_arb
   (
      .pend_i(flags_reg),
      .prio_i(prio_flat),
      .ipl_i(ipl_i),
      .win_o(arb_win),
      .idx_o(arb_idx),
      .lvl_o(arb_lvl)
   );

   // traps outrank all requests; lowest trap number first
   wire logic [7:0] trap_live = trap_i & IVPU_TRAP_IMPL; // [RULE_02]
   logic [2:0] trap_idx;
   always_comb
   begin
      trap_idx = '0;
      for (int i = IVPU_NUM_TRAPS - 1; i >= 0; i--)
      begin
         if (trap_live[i])
         begin
            trap_idx = 3'(i);
         end
      end
   end

   wire logic any_trap = |trap_live;
   wire logic [6:0] req_vnum = arb_idx + IVPU_VEC_OFS; // [RULE_01]
   wire logic [6:0] sel_vnum = any_trap ? {4'h0, trap_idx} : req_vnum;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         irq_reg <= 1'b0;
         trap_reg <= 1'b0;
         vnum_reg <= '0;
         vaddr_reg <= '0;
         lvl_reg <= '0;
      end
      else
      begin
         irq_reg <= any_trap || arb_win;
         trap_reg <= any_trap;
         vnum_reg <= sel_vnum;
         vaddr_reg <= vec_addr(alt_reg, sel_vnum);
         lvl_reg <= any_trap ? '0 : arb_lvl;
      end
   end

   // ************************************************
   // read path
   // ************************************************
   always_comb
   begin
      rdata_next = '0;
      if (flag_sel)
      begin
         rdata_next = flags_reg[flag_lsb +: 16]; // [RULE_11] [RULE_12]
      end
      else if (prio_sel)
      begin
         rdata_next = prio_reg[prio_idx];
      end
      else if (ctrl_sel)
      begin
         rdata_next[IVPU_CTRL_ALT_BIT] = alt_reg;
      end
      else if (stat_sel)
      begin
         rdata_next = {irq_reg, trap_reg, 4'h0, lvl_reg, vnum_reg};
      end
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= rd_i ? rdata_next : '0;
      end
   end

   assign rdata_o = rdata_reg;
   assign irq_o = irq_reg;
   assign trap_o = trap_reg;
   assign vec_num_o = vnum_reg;
   assign vec_addr_o = vaddr_reg;
   assign irq_level_o = lvl_reg;

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   AST_VEC_ADDR: assert property ( // [RULE_01]
      irq_o && !trap_o |-> vec_num_o >= IVPU_VEC_OFS
         && vec_addr_o == vec_addr($past(alt_reg), vec_num_o))
      else $error("request vector address mismatch");
   AST_TRAP_VEC: assert property ( // [RULE_02]
      trap_o |-> vec_num_o < IVPU_VEC_OFS
         && IVPU_TRAP_IMPL[vec_num_o[2:0]])
      else $error("trap vector not a live trap");
   AST_VEC_LAST: assert property ( // [RULE_03]
      irq_o |-> vec_num_o <= IVPU_VEC_LAST)
      else $error("vector beyond last request");
   AST_DMA7: assert property ( // [RULE_04]
      dma_done_i[7] |=> flags_reg[IVPU_DMA_REQ[7]])
      else $error("dma channel 7 flag not set");
   AST_CAN_TX: assert property ( // [RULE_05]
      can_tx_i[1] |=> flags_reg[IVPU_CAN_TX_REQ[1]])
      else $error("second bus transmit flag not set");
   AST_CMP5: assert property ( // [RULE_06]
      cmp_i[0] |=> flags_reg[IVPU_CMP_REQ[0]])
      else $error("compare 5 flag not set");
   AST_EXT4: assert property ( // [RULE_07]
      ext_i[1] |=> flags_reg[IVPU_EXT_REQ[1]])
      else $error("external 4 flag not set");
   AST_SET_WINS: assert property ( // [RULE_08]
      wr_i && flag_sel && wdata_i == 16'h0000 && ser_err_i[0]
         |=> flags_reg[IVPU_SER_ERR_REQ[0]])
      else $error("source set lost to a clear");
   AST_RESV_ZERO: assert property ( // [RULE_12]
      rd_i && addr_i == IVPU_FLAG_BASE + 8'h04
         |=> rdata_o[15:8] == 8'h00 && !rdata_o[3] && !rdata_o[0])
      else $error("unimplemented flag bits read nonzero");
   AST_LEVEL: assert property ( // [RULE_13]
      irq_o && !trap_o |-> irq_level_o != IVPU_PRIO_OFF
         && irq_level_o > $past(ipl_i))
      else $error("request taken at disabled or low level");
   AST_PRIO_RD: assert property ( // [RULE_14]
      rd_i && prio_sel |=> (rdata_o & ~IVPU_PRIO_MASK) == 16'h0000)
      else $error("priority spare bits read nonzero");
   AST_ALT: assert property ( // [RULE_16]
      irq_o && !$past(alt_reg) |-> vec_addr_o < IVPU_ALT_BASE)
      else $error("alternate table used while not selected");

endmodule : ivpu_unit

// >>> src/ivpu_pkg.sv
// constants, register map and request routing for the vector/priority unit
// assumes a single 40 MHz clock and that every request source sits on it
//
// Notes on behaviour
// RULE_01: vector is request plus eight, two apart
// RULE_02: eight trap vectors, only 1 to 5 live
// RULE_03: requests up to 117; reserved ones unconnected
// RULE_04: dma channel completions on fixed request numbers
// RULE_05: bus transmit requests on requests 70, 71
// RULE_06: compare 5-8 and timers 6-9 routed
// RULE_07: second i2c and external 3, 4 routed
// RULE_08: source sets flag; software reads and writes
// RULE_09: fourth flag register bits 7 to 4
// RULE_10: serial error flags at bits 2, 1
// RULE_11: change notify and first i2c flags placed
// RULE_12: unimplemented flag bits read zero, ignore writes
// RULE_13: three-bit priority, zero disables the source
// RULE_14: tenth priority register layout, reset 100
// RULE_15: equal priority: lowest vector number wins
// RULE_16: alternate table only while control bit set
package ivpu_pkg;

   // ************************************************
   // sizes
   // ************************************************
   localparam int IVPU_NUM_REQ = 118;
   localparam int IVPU_REQ_SPACE = 128;
   localparam int IVPU_FLAG_REGS = 8;
   localparam int IVPU_PRIO_REGS = 30;
   localparam int IVPU_FIELDS_PER_REG = 4;
   localparam int IVPU_FIELD_STRIDE = 4;
   localparam int IVPU_PRIO_W = 3;
   localparam int IVPU_NUM_TRAPS = 8;

   // ************************************************
   // register map (word addresses)
   // ************************************************
   localparam logic [7:0] IVPU_FLAG_BASE = 8'h00;
   localparam logic [7:0] IVPU_FLAG_END = 8'h08;
   localparam logic [7:0] IVPU_PRIO_BASE = 8'h10;
   localparam logic [7:0] IVPU_PRIO_END = 8'h2e;
   localparam logic [7:0] IVPU_CTRL_ADDR = 8'h30;
   localparam logic [7:0] IVPU_STAT_ADDR = 8'h31;
   localparam int IVPU_CTRL_ALT_BIT = 0;

   // ************************************************
   // field layouts and reset values
   // ************************************************
   // bank k holds requests 16k..16k+15, so reserved requests read zero
   localparam logic [127:0] IVPU_REQ_IMPL =
      128'h0000_0000_0000_00f6_21ff_dfff_fffb_7fff;
   localparam logic [7:0] IVPU_TRAP_IMPL = 8'h3e;
   localparam logic [15:0] IVPU_PRIO_RST = 16'h4444;
   localparam logic [15:0] IVPU_PRIO_MASK = 16'h7777;
   localparam logic [2:0] IVPU_PRIO_OFF = 3'h0;

   // ************************************************
   // vectors
   // ************************************************
   localparam logic [6:0] IVPU_VEC_OFS = 7'h08;
   localparam logic [6:0] IVPU_VEC_LAST = 7'h7d;
   localparam logic [23:0] IVPU_PRI_BASE = 24'h000004;
   localparam logic [23:0] IVPU_ALT_BASE = 24'h000104;

   // ************************************************
   // request numbers of routed sources
   // ************************************************
   localparam int IVPU_DMA_REQ [8] = '{4, 14, 24, 36, 46, 61, 68, 69};
   localparam int IVPU_CAN_TX_REQ [2] = '{70, 71};
   localparam int IVPU_CMP_REQ [4] = '{41, 42, 43, 44};
   localparam int IVPU_TMR_REQ [4] = '{47, 48, 51, 52};
   localparam int IVPU_I2C2_REQ [2] = '{49, 50};
   localparam int IVPU_EXT_REQ [2] = '{53, 54};
   localparam int IVPU_SER_ERR_REQ [2] = '{65, 66};
   localparam int IVPU_CN_REQ = 19;
   localparam int IVPU_I2C1_MST_REQ = 17;
   localparam int IVPU_I2C1_SLV_REQ = 16;

endpackage : ivpu_pkg

// >>> src/ivpu_arbiter.sv
// priority arbiter over all request flags
// assumes flattened three-bit priority fields, request i at bits 3i+2:3i
module ivpu_arbiter
#(
   parameter int N = 128
)
(
   // pending requests and their levels
   input wire logic [N-1:0] pend_i,
   input wire logic [3*N-1:0] prio_i,
   input wire logic [2:0] ipl_i,
   // winner
   output logic win_o,
   output logic [6:0] idx_o,
   output logic [2:0] lvl_o
);
   import ivpu_pkg::*;

   // ************************************************
   // search
   // ************************************************
   // scanning downward with >= lets the lowest number win a tie
   function automatic logic [10:0] pick
      (input logic [N-1:0] p, input logic [3*N-1:0] lv,
       input logic [2:0] ipl);
      logic [10:0] best;
      logic [2:0] l;
      best = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         l = lv[3*i +: 3];
         if (p[i] && l != IVPU_PRIO_OFF && l > ipl
             && (!best[10] || l >= best[9:7])) // [RULE_13] [RULE_15]
         begin
            best = {1'b1, l, 7'(i)};
         end
      end
      return best;
   endfunction : pick

   wire logic [10:0] res = pick(pend_i, prio_i, ipl_i);
   assign win_o = res[10];
   assign lvl_o = res[9:7];
   assign idx_o = res[6:0];

endmodule : ivpu_arbiter

// >>> sim/ivpu_src_model.sv
// source-side model: pulses one request line for each fire strobe
// assumes fire_i and num_i change just after a rising edge
module ivpu_src_model
(
   // clock and command
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic [6:0] num_i,
   // request lines
   output logic [117:0] src_req_o,
   output logic [7:0] dma_done_o,
   output logic [1:0] can_tx_o,
   output logic [3:0] cmp_o,
   output logic [3:0] tmr_o,
   output logic [1:0] i2c2_o,
   output logic [1:0] ext_o,
   output logic [1:0] ser_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DMA_N [8] = '{4, 14, 24, 36, 46, 61, 68, 69};
   int n;

   // ************************************************
   // one-cycle pulses
   // ************************************************
   initial
   begin
      {src_req_o, dma_done_o, can_tx_o, cmp_o} = '0;
      {tmr_o, i2c2_o, ext_o, ser_err_o} = '0;
   end

   always @(posedge clk_i)
   begin
      n = int'(num_i);
      {src_req_o, dma_done_o, can_tx_o, cmp_o} <= '0;
      {tmr_o, i2c2_o, ext_o, ser_err_o} <= '0;
      if (fire_i)
      begin
         case (n)
            4, 14, 24, 36, 46, 61, 68, 69: ;
            70, 71: can_tx_o[n-70] <= 1'b1;
            41, 42, 43, 44: cmp_o[n-41] <= 1'b1;
            47, 48: tmr_o[n-47] <= 1'b1;
            51, 52: tmr_o[n-49] <= 1'b1;
            49, 50: i2c2_o[n-49] <= 1'b1;
            53, 54: ext_o[n-53] <= 1'b1;
            65, 66: ser_err_o[n-65] <= 1'b1;
            default: src_req_o[n] <= 1'b1;
         endcase
         for (int i = 0; i < 8; i++)
         begin
            if (n == DMA_N[i])
               dma_done_o[i] <= 1'b1;
         end
      end
   end
endmodule : ivpu_src_model

// >>> sim/interrupt_vector_priority_unit_test.sv
// self-checking bench for the vector and priority unit
// assumes one 40 MHz clock; sources come from the source model
module interrupt_vector_priority_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REQS [28] = '{0, 16, 17, 19, 4, 14, 24, 36, 46, 61,
      68, 69, 70, 71, 41, 42, 43, 44, 47, 48, 51, 52, 49, 50, 53, 54,
      65, 66};
   localparam int RSV [5] = '{15, 18, 57, 67, 117};
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr = '0;
   logic [15:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] trap = '0;
   logic [2:0] ipl = '0;
   logic fire = 1'b0;
   logic [6:0] num = '0;
   logic [117:0] src;
   logic [7:0] dma;
   logic [1:0] can;
   logic [3:0] cmp;
   logic [3:0] tmr;
   logic [1:0] i2c;
   logic [1:0] ext;
   logic [1:0] ser;
   logic [15:0] rdata;
   logic irq;
   logic trp;
   logic [6:0] vnum;
   logic [23:0] vaddr;
   logic [2:0] lvl;
   logic [15:0] rv;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   always #12.5 clk_i = ~clk_i;

   ivpu_src_model src_u (.clk_i(clk_i), .fire_i(fire), .num_i(num),
      .src_req_o(src), .dma_done_o(dma), .can_tx_o(can), .cmp_o(cmp),
      .tmr_o(tmr), .i2c2_o(i2c), .ext_o(ext), .ser_err_o(ser));

   ivpu_unit dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .src_req_i(src), .dma_done_i(dma), .can_tx_i(can), .cmp_i(cmp),
      .tmr_i(tmr), .i2c2_i(i2c), .ext_i(ext), .ser_err_i(ser),
      .trap_i(trap), .ipl_i(ipl), .irq_o(irq), .trap_o(trp),
      .vec_num_o(vnum), .vec_addr_o(vaddr), .irq_level_o(lvl));

   // ************************************************
   // helpers
   // ************************************************
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(24'(rdata), 24'(exp));
   endtask : rd_chk

   task settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle

   // flag one edge after the pulse, vector one edge after that
   task fire_req(input int n);
      @(posedge clk_i);
      fire <= 1'b1;
      num <= 7'(n);
      @(posedge clk_i);
      fire <= 1'b0;
      settle();
   endtask : fire_req

   task give_verdict();
      $display("errors %0d of %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // ************************************************
   // sequence
   // ************************************************
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd_chk(8'h1a, 16'h4444);
      rd_chk(8'h04, 16'h0000);
      wr_reg(8'h1a, 16'hffff);
      rd_chk(8'h1a, 16'h7777);
      wr_reg(8'h1a, 16'h4444);
      wr_reg(8'h04, 16'hffff);
      rd_chk(8'h04, 16'h00f6);
      wr_reg(8'h04, 16'h0000);
      rd_chk(8'h04, 16'h0000);
      // source pulse lands in the cycle of a clearing write: set wins
      @(posedge clk_i);
      fire <= 1'b1;
      num <= 7'd65;
      @(posedge clk_i);
      fire <= 1'b0;
      wr <= 1'b1;
      addr <= 8'h04;
      wdata <= 16'h0000;
      @(posedge clk_i);
      wr <= 1'b0;
      rd_chk(8'h04, 16'h0002);
      wr_reg(8'h04, 16'h0000);
      wr_reg(8'h01, 16'h000f);
      rd_chk(8'h01, 16'h000b);
      wr_reg(8'h01, 16'h0000);
      rd_chk(8'h40, 16'h0000);
      foreach (REQS[i])
      begin
         fire_req(REQS[i]);
         chk(24'(irq), 24'h1);
         chk(24'(trp), 24'h0);
         chk(24'(vnum), 24'(REQS[i] + 8));
         chk(vaddr, 24'(20 + 2 * REQS[i]));
         wr_reg(8'(REQS[i] / 16), 16'h0000);
      end
      foreach (RSV[i])
      begin
         fire_req(RSV[i]);
         chk(24'(irq), 24'h0);
      end
      wr_reg(8'h30, 16'h0001);
      fire_req(70);
      chk(vaddr, 24'h0001a0);
      wr_reg(8'h30, 16'h0000);
      settle();
      chk(vaddr, 24'h0000a0);
      wr_reg(8'h04, 16'h0000);
      fire_req(42);
      fire_req(41);
      chk(24'(vnum), 24'd49);
      rd_chk(8'h31, 16'h8231);
      wr_reg(8'h1a, 16'h0700);
      settle();
      chk(24'(vnum), 24'd50);
      chk(24'(lvl), 24'd7);
      @(posedge clk_i);
      ipl <= 3'h7;
      settle();
      chk(24'(irq), 24'h0);
      wr_reg(8'h1a, 16'h0000);
      ipl <= 3'h0;
      settle();
      chk(24'(irq), 24'h0);
      wr_reg(8'h1a, 16'h4444);
      wr_reg(8'h02, 16'h0000);
      for (int t = 0; t < 8; t++)
      begin
         @(posedge clk_i);
         trap <= 8'(1 << t);
         @(posedge clk_i);
         #1 chk(24'(irq), 24'(t inside {[1:5]}));
         if (t inside {[1:5]})
         begin
            chk(24'(trp), 24'h1);
            chk(vaddr, 24'(4 + 2 * t));
         end
         @(posedge clk_i);
         trap <= '0;
      end
      give_verdict();
   end
endmodule : interrupt_vector_priority_unit_test
